/* File: rtl/hcwi_pkg.sv */
package hcwi_pkg;
  // Register indices; byte address is not used on this plain port
  localparam logic [3:0] ADDR_COPY_SOURCE = 4'h1;
  localparam logic [3:0] ADDR_COPY_DEST = 4'h2;
  localparam logic [3:0] ADDR_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_NOTIFY = 4'h5;
  localparam logic [3:0] ADDR_TABLE_SEL = 4'h6;
  localparam logic [3:0] ADDR_TABLE_DATA = 4'h7;
  // Control word fields
  localparam int CTL_NUMERIC_BIT = 2;
  localparam int CTL_COPY_BIT = 3;
  localparam int CTL_PRINT_BIT = 7;
  localparam int NOTIFY_PRINTING_BIT = 7;
  // Special table numbers
  localparam logic [7:0] TBL_SEC = 8'hf7;
  localparam logic [7:0] TBL_DOW = 8'hfd;
  localparam logic [7:0] TBL_SET_LOW = 8'hfe;
  localparam logic [7:0] TBL_SET_HIGH = 8'hff;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Clock tick timing
  localparam longint CLK_HZ = 25000000;
  localparam longint TICK_PERIOD_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam longint TICKS_PER_SEC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Printer run time in cycles
  localparam longint PRINT_CYCLES_DEF = 1000000;
  typedef enum logic [1:0] {
    HCWI_IDLE = 2'b00,
    HCWI_COPY = 2'b01,
    HCWI_WAIT_CLR = 2'b10
  } hcwi_copy_type;
endpackage

/* File: rtl/hcwi_top.sv */
`timescale 1ns/100ps
// What this block does
// R1: Copy source table number comes from control word one.
// R2: Copy destination table number comes from control word two.
// R3: Host writes table numbers as four-digit BCD.
// R4: Control bit 2 set selects numeric table copies.
// R5: Control bit 3 set copies source table into destination table.
// R6: Copy into table 254 loads date, hour, minute, second.
// R7: Copy into table 255 loads weekday, year, month.
// R8: Host gives clock setting values in BCD digits.
// R9: Tables 247 to 253 always hold running time within ranges.
// R10: Clock tables hold time as unsigned binary, not BCD.
// R11: Host waits about a second, clears copy bit, waits again.
// R12: Notify bit 7 shows printer active, one while printing.
// R13: Control bit 7 set requests a screen hard copy.
// R14: Host checks printer bit is zero before print request.
// R15: Print request during a print is ignored.
// R16: A started print cannot be stopped.
// R17: Control words keep working while printing.
// R18: Host writes to clock tables 247 to 253 are refused.
// R19: Copy runs once per rising copy bit, rearms after clear.
module hcwi_top
  import hcwi_pkg::*;
#(
  parameter longint TICK_CYCLES = TICKS_PER_SEC,
  parameter longint PRINT_CYCLES = PRINT_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic PRINT_START,
  output logic CLOCK_LOADED
);
  // Host side command words
  logic [15:0] copy_source;
  logic [15:0] copy_dest;
  logic [15:0] control_word;
  logic [7:0] table_sel;

  // Table store and copy path
  logic [15:0] tables [0:255];
  logic [31:0] src_value;
  hcwi_copy_type copy_state;
  logic copy_armed;

  // Calendar clock fields and carries
  logic [31:0] tick_cnt;
  logic [31:0] next_tick;
  logic clock_step;
  logic sec_carry;
  logic min_carry;
  logic hour_carry;
  logic date_carry;
  logic month_carry;
  logic [6:0] sec;
  logic [6:0] min;
  logic [6:0] hour;
  logic [6:0] date;
  logic [6:0] month;
  logic [6:0] year;
  logic [6:0] dow;
  logic set_low;
  logic set_high;

  // Printer run
  logic [31:0] print_cnt;
  logic printing;
  logic print_prev;

  // BCD word to binary table number
  function automatic logic [7:0] bcd4_to_bin(input logic [15:0] b);
    logic [15:0] v;
    v = 16'(b[15:12]) * 16'd1000 + 16'(b[11:8]) * 16'd100
      + 16'(b[7:4]) * 16'd10 + 16'(b[3:0]);
    return v[7:0];
  endfunction

  // Two BCD digits to binary
  function automatic logic [6:0] bcd2(input logic [7:0] b);
    return 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
  endfunction

  // Table numbers decoded from BCD
  wire [7:0] src_num = bcd4_to_bin(copy_source); // R1 R3
  wire [7:0] dst_num = bcd4_to_bin(copy_dest); // R2 R3
  wire host_tbl_ok = (table_sel < TBL_SEC) || (table_sel > TBL_DOW);

  // Host command words
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      copy_source <= RESET_WORD;
      copy_dest <= RESET_WORD;
      control_word <= RESET_WORD;
      table_sel <= 8'h00;
    end else if (WR) begin
      case (ADDR)
        ADDR_COPY_SOURCE: copy_source <= WDATA; // R1
        ADDR_COPY_DEST: copy_dest <= WDATA; // R2
        ADDR_CONTROL: control_word <= WDATA; // R17
        ADDR_TABLE_SEL: table_sel <= WDATA[7:0];
        default: ;
      endcase
    end
  end

  // Table store: host writes and copies
  always_ff @(posedge MCLK) begin
    if (WR && ADDR == ADDR_TABLE_DATA && host_tbl_ok) begin
      tables[table_sel] <= WDATA; // R18
    end
    if (copy_state == HCWI_COPY && (dst_num < TBL_SEC || dst_num > TBL_DOW)) begin
      tables[dst_num] <= src_value[15:0]; // R5
      if (dst_num != TBL_SET_HIGH) begin
        tables[8'(dst_num + 8'h01)] <= src_value[31:16];
      end
    end
  end

  assign src_value = {tables[8'(src_num + 8'h01)], tables[src_num]};

  // Copy sequencer, one copy per rising execute bit
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      copy_state <= HCWI_IDLE;
      copy_armed <= 1'b0;
    end else begin
      case (copy_state)
        HCWI_IDLE: begin
          if (!control_word[CTL_COPY_BIT]) begin
            copy_armed <= 1'b1; // R19
          end else if (copy_armed && control_word[CTL_NUMERIC_BIT]) begin
            copy_state <= HCWI_COPY; // R4 R5 R19
            copy_armed <= 1'b0;
          end
        end
        HCWI_COPY: copy_state <= HCWI_WAIT_CLR;
        HCWI_WAIT_CLR: if (!control_word[CTL_COPY_BIT]) copy_state <= HCWI_IDLE; // R19
        default: copy_state <= HCWI_IDLE;
      endcase
    end
  end

  // Clock load strobes from a copy into the setting tables
  assign set_low = copy_state == HCWI_COPY && dst_num == TBL_SET_LOW;
  assign set_high = copy_state == HCWI_COPY && dst_num == TBL_SET_HIGH;
  assign next_tick = (tick_cnt >= 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;

  // Carry chain; a load cycle holds the running time
  assign clock_step = !set_low && !set_high && next_tick == 32'h0;
  assign sec_carry = clock_step && sec >= 7'd59;
  assign min_carry = sec_carry && min >= 7'd59;
  assign hour_carry = min_carry && hour >= 7'd23;
  assign date_carry = hour_carry && date >= 7'd31;
  assign month_carry = date_carry && month >= 7'd12;

  // Second prescaler, restarted by a time load
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt <= 32'h0;
    end else if (set_low) begin
      tick_cnt <= 32'h0;
    end else if (!set_high) begin
      tick_cnt <= next_tick;
    end
  end

  // Seconds
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sec <= 7'h00;
    end else if (set_low) begin
      sec <= bcd2(src_value[7:0]); // R6 R8
    end else if (clock_step) begin
      sec <= sec_carry ? 7'h00 : sec + 7'h01; // R9
    end
  end

  // Minutes
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      min <= 7'h00;
    end else if (set_low) begin
      min <= bcd2(src_value[15:8]); // R6 R8
    end else if (sec_carry) begin
      min <= min_carry ? 7'h00 : min + 7'h01; // R9
    end
  end

  // Hours, 24 hour count
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hour <= 7'h00;
    end else if (set_low) begin
      hour <= bcd2(src_value[23:16]); // R6 R8
    end else if (min_carry) begin
      hour <= hour_carry ? 7'h00 : hour + 7'h01; // R9
    end
  end

  // Date, rolls at 31 in every month
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      date <= 7'h01;
    end else if (set_low) begin
      date <= bcd2(src_value[31:24]); // R6 R8
    end else if (hour_carry) begin
      date <= date_carry ? 7'h01 : date + 7'h01; // R9
    end
  end

  // Day of week
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dow <= 7'h00;
    end else if (set_high) begin
      dow <= bcd2(src_value[31:24]); // R7 R8
    end else if (hour_carry) begin
      dow <= (dow < 7'd6) ? dow + 7'h01 : 7'h00; // R9
    end
  end

  // Month
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      month <= 7'h01;
    end else if (set_high) begin
      month <= bcd2(src_value[15:8]); // R7 R8
    end else if (date_carry) begin
      month <= month_carry ? 7'h01 : month + 7'h01; // R9
    end
  end

  // Year, last two digits
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      year <= 7'h00;
    end else if (set_high) begin
      year <= bcd2(src_value[23:16]); // R7 R8
    end else if (month_carry) begin
      year <= (year < 7'd99) ? year + 7'h01 : 7'h00; // R9
    end
  end

  // Printer run, start on rising request only when idle
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      printing <= 1'b0;
      print_cnt <= 32'h0;
      print_prev <= 1'b0;
      PRINT_START <= 1'b0;
    end else begin
      print_prev <= control_word[CTL_PRINT_BIT];
      PRINT_START <= 1'b0;
      if (printing) begin
        // R15 R16: no abort, new requests ignored
        if (print_cnt >= 32'(PRINT_CYCLES - 1)) printing <= 1'b0;
        else print_cnt <= print_cnt + 32'h1;
      end else if (control_word[CTL_PRINT_BIT] && !print_prev) begin
        printing <= 1'b1; // R13
        print_cnt <= 32'h0;
        PRINT_START <= 1'b1;
      end
    end
  end

  // Clock load pulse
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) CLOCK_LOADED <= 1'b0;
    else CLOCK_LOADED <= set_low | set_high;
  end

  // Read data, one cycle after read strobe
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) RDATA <= 16'h0000;
    else if (RD) begin
      case (ADDR)
        ADDR_COPY_SOURCE: RDATA <= copy_source;
        ADDR_COPY_DEST: RDATA <= copy_dest;
        ADDR_CONTROL: RDATA <= control_word;
        ADDR_NOTIFY: RDATA <= 16'(printing) << NOTIFY_PRINTING_BIT; // R12
        ADDR_TABLE_SEL: RDATA <= {8'h00, table_sel};
        ADDR_TABLE_DATA: begin
          // Clock tables show the live counters
          case (table_sel)
            8'hf7: RDATA <= {9'h000, sec}; // R9 R10
            8'hf8: RDATA <= {9'h000, min};
            8'hf9: RDATA <= {9'h000, hour};
            8'hfa: RDATA <= {9'h000, date};
            8'hfb: RDATA <= {9'h000, month};
            8'hfc: RDATA <= {9'h000, year};
            8'hfd: RDATA <= {9'h000, dow};
            default: RDATA <= tables[table_sel];
          endcase
        end
        default: RDATA <= 16'h0000;
      endcase
    end else RDATA <= 16'h0000;
  end
endmodule

/* File: tb/hcwi_top_asserts.sv */
`timescale 1ns/100ps
module hcwi_top_asserts
  import hcwi_pkg::*;
#(
  parameter longint PRINT_CYCLES = 20
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic PRINT_START,
  input wire logic CLOCK_LOADED
);
  logic [31:0] busy;
  wire logic ctl_wr = WR && ADDR == ADDR_CONTROL;
  wire logic copy_wr = ctl_wr && WDATA[CTL_NUMERIC_BIT] && WDATA[CTL_COPY_BIT];
  wire logic prt_wr = ctl_wr && WDATA[CTL_PRINT_BIT];
  // Cycles left in the print window, with margin
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) busy <= '0;
    else if (PRINT_START) busy <= 32'(PRINT_CYCLES + 3);
    else if (busy != 32'h0) busy <= busy - 32'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_start;
    PRINT_START ##1 !PRINT_START;
  endsequence
  sequence s_notify_rd;
    $past(RD) && $past(ADDR) == ADDR_NOTIFY;
  endsequence
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data present without a read");
  print_cause_a: assert property (PRINT_START |-> $past(prt_wr) || $past(prt_wr, 2))
    else $error("print start without a print request");
  print_pulse_a: assert property (PRINT_START |-> s_start)
    else $error("print start longer than one cycle");
  print_once_a: assert property (PRINT_START |-> busy == 32'h0)
    else $error("print started while printing");
  notify_busy_a: assert property (s_notify_rd ##0 (busy >= 5 && busy <= PRINT_CYCLES)
    |-> RDATA[NOTIFY_PRINTING_BIT])
    else $error("printing flag low during print");
  notify_idle_a: assert property (s_notify_rd ##0 (busy == 32'h0 && !PRINT_START)
    |-> !RDATA[NOTIFY_PRINTING_BIT])
    else $error("printing flag high while stopped");
  load_cause_a: assert property (CLOCK_LOADED
    |-> $past(copy_wr, 2) || $past(copy_wr, 3) || $past(copy_wr, 4))
    else $error("clock loaded without numeric copy");
  load_once_a: assert property (CLOCK_LOADED |=> !CLOCK_LOADED [*3])
    else $error("clock loaded twice for one copy");
endmodule
bind hcwi_top hcwi_top_asserts #(.PRINT_CYCLES(PRINT_CYCLES)) i_hcwi_top_asserts (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PRINT_START(PRINT_START), .CLOCK_LOADED(CLOCK_LOADED));

/* File: tb/hcwi_printer_model.sv */
`timescale 1ns/100ps
module hcwi_printer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic print_start,
  input wire logic clock_loaded,
  output int prints,
  output int loads
);
  // Printer port never aborts a started job, only counts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prints <= 0;
    else if (print_start) prints <= prints + 1;
  end
  // Calendar clock load events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) loads <= 0;
    else if (clock_loaded) loads <= loads + 1;
  end
endmodule

/* File: tb/tb_host_control_word_interface.sv */
`timescale 1ns/100ps
module tb_host_control_word_interface;
  import hcwi_pkg::*;
  logic MCLK = 0, SYS_RST = 1, WR = 0, RD = 0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000, v;
  wire logic [15:0] RDATA;
  wire logic PRINT_START, CLOCK_LOADED;
  int err_count = 0, tests_run = 0, prints, loads;
  logic [35:0] rows [3] = '{{4'h1, 16'h0016, 16'h0016}, {4'h2, 16'h0254, 16'h0254},
    {4'hf, 16'h1234, 16'h0000}};
  localparam int ONE_SEC = 1000;
  hcwi_top #(.TICK_CYCLES(ONE_SEC), .PRINT_CYCLES(20)) i_hcwi_top (.MCLK(MCLK),
    .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PRINT_START(PRINT_START), .CLOCK_LOADED(CLOCK_LOADED));
  hcwi_printer_model i_hcwi_printer_model (.clk(MCLK), .rst(SYS_RST), .print_start(PRINT_START),
    .clock_loaded(CLOCK_LOADED), .prints(prints), .loads(loads));
  initial forever #20 MCLK = ~MCLK;
  task chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
    @(posedge MCLK) WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge MCLK) {RD, ADDR} <= {1'b1, a};
    @(posedge MCLK) RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task tw(input logic [7:0] n, input logic [15:0] d);
    wr(ADDR_TABLE_SEL, {8'h00, n});
    wr(ADDR_TABLE_DATA, d);
  endtask
  task tr(input logic [7:0] n, input logic [15:0] e);
    wr(ADDR_TABLE_SEL, {8'h00, n});
    rd(ADDR_TABLE_DATA);
    chk(v, e);
  endtask
  task final_report;
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK) #1 chk(RDATA, 16'h0000);
    rd(ADDR_NOTIFY);
    chk(v & 16'h0080, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][35:32], rows[i][31:16]);
      rd(rows[i][35:32]);
      chk(v, rows[i][15:0]);
    end
    $display("register test done");
    tw(8'h10, 16'h5330);
    tw(8'h11, 16'h2714);
    tw(8'h12, 16'h0300);
    tw(8'h13, 16'h0598);
    wr(ADDR_CONTROL, 16'h000c);
    wr(ADDR_CONTROL, 16'h000c);
    repeat (ONE_SEC) @(posedge MCLK);
    wr(ADDR_CONTROL, 16'h0000);
    repeat (ONE_SEC) @(posedge MCLK);
    tw(TBL_SEC, 16'h00aa);
    tr(TBL_SEC, 16'h0020);
    tr(8'hf8, 16'h0035);
    tr(8'hf9, 16'h000e);
    tr(8'hfa, 16'h001b);
    wr(ADDR_COPY_SOURCE, 16'h0018);
    wr(ADDR_COPY_DEST, 16'h0255);
    wr(ADDR_CONTROL, 16'h000c);
    repeat (ONE_SEC) @(posedge MCLK);
    wr(ADDR_CONTROL, 16'h0000);
    repeat (ONE_SEC) @(posedge MCLK);
    wr(ADDR_CONTROL, 16'h0008);
    wr(ADDR_CONTROL, 16'h0000);
    tr(8'hfb, 16'h0003);
    tr(8'hfc, 16'h0062);
    tr(TBL_DOW, 16'h0005);
    chk(16'(loads), 16'h0002);
    repeat (1300) @(posedge MCLK);
    tr(TBL_SEC, 16'h0023);
    $display("clock test done");
    rd(ADDR_NOTIFY);
    chk(v & 16'h0080, 16'h0000);
    wr(ADDR_CONTROL, 16'h0080);
    rd(ADDR_NOTIFY);
    chk(v & 16'h0080, 16'h0080);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h0080);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_NOTIFY);
    chk(v & 16'h0080, 16'h0080);
    rd(ADDR_COPY_SOURCE);
    chk(v, 16'h0018);
    repeat (30) @(posedge MCLK);
    rd(ADDR_NOTIFY);
    chk(v & 16'h0080, 16'h0000);
    chk(16'(prints), 16'h0001);
    $display("print test done");
    @(posedge MCLK) SYS_RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rd(ADDR_COPY_SOURCE);
    chk(v, 16'h0000);
    rd(ADDR_CONTROL);
    chk(v, 16'h0000);
    $display("second reset test done");
    final_report();
  end
endmodule
